/* File: design/adc_cfg_pkg.sv */
// Constants, register map and carrier types for the converter output path.
// Assumes a single 100 MHz clock and a plain strobe-based register port.
`default_nettype none
package adc_cfg_pkg;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] ADDR_MODE_FMT = 8'h50;
   localparam logic [7:0] ADDR_USER_LO = 8'h51;
   localparam logic [7:0] ADDR_USER_HI = 8'h52;
   localparam logic [7:0] ADDR_LOOP_EN_A = 8'h53;
   localparam logic [7:0] ADDR_GAIN_TC_A = 8'h55;
   localparam logic [7:0] ADDR_TRIM_A = 8'h57;
   localparam logic [7:0] ADDR_PAT_A = 8'h62;
   localparam logic [7:0] ADDR_PED_A = 8'h63;
   localparam logic [7:0] ADDR_LOOP_EN_B = 8'h66;
   localparam logic [7:0] ADDR_GAIN_TC_B = 8'h68;
   localparam logic [7:0] ADDR_TRIM_B = 8'h6a;
   localparam logic [7:0] ADDR_PAT_B = 8'h75;
   localparam logic [7:0] ADDR_PED_B = 8'h76;
   localparam int BIT_SW_RESET = 7;
   localparam int BIT_INDEP = 6;
   localparam int BIT_LOOP_EN = 6;
   localparam int BIT_NSF = 7;
   localparam logic [1:0] FMT_TWOS = 2'h2;
   localparam logic [1:0] FMT_OFFBIN = 2'h3;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [3:0] GAIN_MAX = 4'hc;
   localparam logic [3:0] TC_MAX = 4'hb;
   localparam int TC_BASE_LOG2 = 18;
   localparam int TRIM_SHIFT = 13;
   localparam int RAMP_DIV_12 = 4;
   typedef enum logic [2:0] {
      PAT_NORMAL, PAT_ZEROS, PAT_ONES, PAT_TOGGLE, PAT_RAMP, PAT_USER, PAT_UNUSED6, PAT_UNUSED7
   } pattern_t;
   typedef struct packed {
      logic loop_en;
      logic [3:0] gain;
      logic [3:0] time_const;
      logic [6:0] trim;
      pattern_t pattern;
      logic [5:0] pedestal;
      logic noise_shaping_feature;
   } chan_cfg_t;
endpackage
`default_nettype wire

/* File: design/adc_output_config_bank.sv */
// Register bank and output data path for a dual channel sampling converter.
// Assumes samples arrive on the same clock as the register port, one per cycle.
`timescale 1ns/10ps
`default_nettype none
module adc_output_config_bank #(
   parameter int WIDTH = 14
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic sample_valid_in,
   input wire logic [WIDTH-1:0] sample_a_in,
   input wire logic [WIDTH-1:0] sample_b_in,
   output logic [WIDTH-1:0] data_a_out,
   output logic [WIDTH-1:0] data_b_out,
   output logic data_valid_out,
   output logic [1:0] loop_on_out,
   output logic [1:0] noise_shaping_feature_out
);
   // Only the 12-bit and 14-bit output words are served by the ramp and mid-scale logic.
   if (WIDTH != 14 && WIDTH != 12) begin : g_width_check
      $error("WIDTH must be 12 or 14");
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   // Samples are unsigned offset binary, mid-scale at half range.
   localparam logic [WIDTH-1:0] MID = WIDTH'(1) << (WIDTH - 1);
   localparam int ACC_W = WIDTH + 30;

   typedef struct packed {
      logic indep;
      logic [1:0] fmt;
      logic [7:0] user_lo;
      logic [5:0] user_hi;
      adc_cfg_pkg::chan_cfg_t [1:0] cfg;
      logic [7:0] rdata;
      logic [WIDTH-1:0] ramp;
      logic [1:0] ramp_div;
      logic toggle;
      logic signed [1:0][ACC_W-1:0] acc;
      logic [1:0][WIDTH-1:0] out;
      logic valid;
   } state_t;

   state_t st;
   state_t next_st;
   adc_cfg_pkg::chan_cfg_t [1:0] eff;
   logic [WIDTH-1:0] user_word;
   logic [WIDTH-1:0] toggle_word;

   function automatic logic [7:0] pack_gain_tc(input adc_cfg_pkg::chan_cfg_t c);
      return {c.gain, c.time_const};
   endfunction

   always_comb begin
      // channel B inherits A's set unless independent control is on.
      eff[0] = st.cfg[0];
      eff[1] = st.indep ? st.cfg[1] : st.cfg[0];
      user_word = WIDTH'({st.user_hi, st.user_lo});
      for (int i = 0; i < WIDTH; i++) begin
         toggle_word[i] = st.toggle ^ ~i[0];
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [WIDTH-1:0] raw;
      logic [WIDTH+7:0] scaled;
      logic [WIDTH+8:0] coarse;
      logic [WIDTH-1:0] corr;
      logic signed [WIDTH+1:0] err;
      logic [4:0] shift;
      logic [WIDTH-1:0] fmt_word;
      logic [WIDTH-1:0] target;
      raw = '0;
      scaled = '0;
      coarse = '0;
      corr = '0;
      err = '0;
      shift = '0;
      fmt_word = '0;
      target = '0;
      next_st = st;
      next_st.rdata = '0;

      if (st.valid || sample_valid_in) begin
         next_st.toggle = ~st.toggle;
      end
      // 12-bit ramp advances every fourth sample, 14-bit on each one.
      if (sample_valid_in) begin
         next_st.ramp_div = st.ramp_div + 2'h1;
         if (WIDTH == 14 || st.ramp_div == 2'(adc_cfg_pkg::RAMP_DIV_12 - 1)) begin
            next_st.ramp = st.ramp + WIDTH'(1);
         end
      end
      next_st.valid = sample_valid_in;

      for (int c = 0; c < 2; c++) begin
         raw = c == 0 ? sample_a_in : sample_b_in;
         // coarse gain as roughly 0.5 dB per step, 6 % per code.
         coarse = (WIDTH+9)'(raw) + (((WIDTH+9)'(raw) * (WIDTH+9)'(eff[c].gain)) >> 4);
         // trim only adds, coarse*(1 + trim/8192).
         scaled = (WIDTH+8)'(coarse + ((coarse * (WIDTH+9)'(eff[c].trim)) >> adc_cfg_pkg::TRIM_SHIFT));
         // Gain is about code zero and only adds, so a saturated result clips to full scale.
         corr = scaled > (WIDTH+8)'({WIDTH{1'b1}}) ? {WIDTH{1'b1}} : scaled[WIDTH-1:0];
         // loop drives output toward mid-scale plus signed pedestal.
         target = MID + WIDTH'(signed'(eff[c].pedestal));
         // An element of the packed array is unsigned, so it is made signed before the shift.
         corr = corr - WIDTH'(signed'(st.acc[c]) >>> 30);
         if (eff[c].loop_en && sample_valid_in) begin
            err = signed'({2'b00, corr}) - signed'({2'b00, target});
            // step is error over 2^(18+code) cycles, with codes above 11 taken as 11.
            shift = 5'(adc_cfg_pkg::TC_BASE_LOG2 + int'(eff[c].time_const > adc_cfg_pkg::TC_MAX ?
                    adc_cfg_pkg::TC_MAX : eff[c].time_const));
            next_st.acc[c] = st.acc[c] + ((ACC_W'(signed'(err)) <<< 30) >>> shift);
         end else if (!eff[c].loop_en) begin
            next_st.acc[c] = '0;
         end
         // two's complement flips the top bit of offset binary.
         fmt_word = st.fmt == adc_cfg_pkg::FMT_TWOS ? corr ^ MID : corr;
         // patterns bypass formatting and replace the data word.
         case (eff[c].pattern)
            adc_cfg_pkg::PAT_NORMAL: next_st.out[c] = fmt_word;
            adc_cfg_pkg::PAT_ZEROS: next_st.out[c] = '0;
            adc_cfg_pkg::PAT_ONES: next_st.out[c] = '1;
            adc_cfg_pkg::PAT_TOGGLE: next_st.out[c] = toggle_word;
            adc_cfg_pkg::PAT_RAMP: next_st.out[c] = st.ramp;
            adc_cfg_pkg::PAT_USER: next_st.out[c] = user_word;
            default: next_st.out[c] = fmt_word;
         endcase
      end

      if (rd_in) begin
         case (addr_in)
            adc_cfg_pkg::ADDR_MODE_FMT: next_st.rdata = {1'b0, st.indep, 3'h0, st.fmt, 1'b0};
            adc_cfg_pkg::ADDR_USER_LO: next_st.rdata = st.user_lo;
            adc_cfg_pkg::ADDR_USER_HI: next_st.rdata = {2'h0, st.user_hi};
            adc_cfg_pkg::ADDR_LOOP_EN_A: next_st.rdata = {1'b0, st.cfg[0].loop_en, 6'h0};
            adc_cfg_pkg::ADDR_GAIN_TC_A: next_st.rdata = pack_gain_tc(st.cfg[0]);
            adc_cfg_pkg::ADDR_TRIM_A: next_st.rdata = {st.cfg[0].noise_shaping_feature, st.cfg[0].trim};
            adc_cfg_pkg::ADDR_PAT_A: next_st.rdata = {5'h0, st.cfg[0].pattern};
            adc_cfg_pkg::ADDR_PED_A: next_st.rdata = {2'h0, st.cfg[0].pedestal};
            adc_cfg_pkg::ADDR_LOOP_EN_B: next_st.rdata = {1'b0, st.cfg[1].loop_en, 6'h0};
            adc_cfg_pkg::ADDR_GAIN_TC_B: next_st.rdata = pack_gain_tc(st.cfg[1]);
            adc_cfg_pkg::ADDR_TRIM_B: next_st.rdata = {st.cfg[1].noise_shaping_feature, st.cfg[1].trim};
            adc_cfg_pkg::ADDR_PAT_B: next_st.rdata = {5'h0, st.cfg[1].pattern};
            adc_cfg_pkg::ADDR_PED_B: next_st.rdata = {2'h0, st.cfg[1].pedestal};
            default: next_st.rdata = adc_cfg_pkg::RESET_VALUE;
         endcase
      end

      if (wr_in) begin
         case (addr_in)
            adc_cfg_pkg::ADDR_RESET: begin
               // bit is never stored, so it reads back as zero.
               if (wdata_in[adc_cfg_pkg::BIT_SW_RESET]) begin
                  next_st.indep = 1'b0;
                  next_st.fmt = '0;
                  next_st.user_lo = '0;
                  next_st.user_hi = '0;
                  next_st.cfg = '0;
                  next_st.acc = '0;
               end
            end
            adc_cfg_pkg::ADDR_MODE_FMT: begin
               next_st.indep = wdata_in[adc_cfg_pkg::BIT_INDEP];
               next_st.fmt = wdata_in[2:1];
            end
            adc_cfg_pkg::ADDR_USER_LO: next_st.user_lo = wdata_in;
            adc_cfg_pkg::ADDR_USER_HI: next_st.user_hi = wdata_in[5:0];
            adc_cfg_pkg::ADDR_LOOP_EN_A: next_st.cfg[0].loop_en = wdata_in[adc_cfg_pkg::BIT_LOOP_EN];
            adc_cfg_pkg::ADDR_GAIN_TC_A: begin
               next_st.cfg[0].gain = wdata_in[7:4];
               next_st.cfg[0].time_const = wdata_in[3:0];
            end
            adc_cfg_pkg::ADDR_TRIM_A: begin
               next_st.cfg[0].trim = wdata_in[6:0];
               next_st.cfg[0].noise_shaping_feature = wdata_in[adc_cfg_pkg::BIT_NSF];
            end
            adc_cfg_pkg::ADDR_PAT_A: next_st.cfg[0].pattern = adc_cfg_pkg::pattern_t'(wdata_in[2:0]);
            adc_cfg_pkg::ADDR_PED_A: next_st.cfg[0].pedestal = wdata_in[5:0];
            adc_cfg_pkg::ADDR_LOOP_EN_B: next_st.cfg[1].loop_en = wdata_in[adc_cfg_pkg::BIT_LOOP_EN];
            adc_cfg_pkg::ADDR_GAIN_TC_B: begin
               next_st.cfg[1].gain = wdata_in[7:4];
               next_st.cfg[1].time_const = wdata_in[3:0];
            end
            adc_cfg_pkg::ADDR_TRIM_B: begin
               next_st.cfg[1].trim = wdata_in[6:0];
               next_st.cfg[1].noise_shaping_feature = wdata_in[adc_cfg_pkg::BIT_NSF];
            end
            adc_cfg_pkg::ADDR_PAT_B: next_st.cfg[1].pattern = adc_cfg_pkg::pattern_t'(wdata_in[2:0]);
            adc_cfg_pkg::ADDR_PED_B: next_st.cfg[1].pedestal = wdata_in[5:0];
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_out = st.rdata;
   assign data_a_out = st.out[0];
   assign data_b_out = st.out[1];
   assign data_valid_out = st.valid;
   assign loop_on_out = {eff[1].loop_en, eff[0].loop_en};
   assign noise_shaping_feature_out = {eff[1].noise_shaping_feature, eff[0].noise_shaping_feature};
endmodule // adc_output_config_bank
`default_nettype wire

/* File: sim/adc_output_config_bank_checker.sv */
// Port-level assertions for the converter output register bank.
// Assumes one clock and shadows the written registers it needs.
`timescale 1ns/10ps
`default_nettype none
module adc_output_config_bank_checker #(
   parameter int WIDTH = 14
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic sample_valid_in,
   input wire logic [WIDTH-1:0] sample_a_in,
   input wire logic [WIDTH-1:0] sample_b_in,
   input wire logic [WIDTH-1:0] data_a_out,
   input wire logic [WIDTH-1:0] data_b_out,
   input wire logic data_valid_out,
   input wire logic [1:0] loop_on_out,
   input wire logic [1:0] noise_shaping_feature_out
);
   logic [7:0] lo, hi, mode;
   logic [2:0] pat;
   logic le_a, tw;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         {lo, hi, mode, pat, le_a, tw} <= '0;
      end else if (wr_in && addr_in == adc_cfg_pkg::ADDR_RESET && wdata_in[7]) begin
         {lo, hi, mode, pat, le_a, tw} <= '0;
      end else if (wr_in) begin
         case (addr_in)
            adc_cfg_pkg::ADDR_USER_LO: lo <= wdata_in;
            adc_cfg_pkg::ADDR_USER_HI: hi <= wdata_in;
            adc_cfg_pkg::ADDR_MODE_FMT: mode <= wdata_in;
            adc_cfg_pkg::ADDR_PAT_A: pat <= wdata_in[2:0];
            adc_cfg_pkg::ADDR_LOOP_EN_A: le_a <= wdata_in[6];
            // Any channel A gain or trim write makes the plain data path unpredictable here.
            adc_cfg_pkg::ADDR_GAIN_TC_A, adc_cfg_pkg::ADDR_TRIM_A: tw <= 1'b1;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   chk_read_lo: assert property (
      rd_in && addr_in == adc_cfg_pkg::ADDR_USER_LO |=> rdata_out == $past(lo))
      else $error("low user byte read back wrong");
   chk_read_hi: assert property (
      rd_in && addr_in == adc_cfg_pkg::ADDR_USER_HI |=> rdata_out == {2'b00, $past(hi[5:0])})
      else $error("high user bits read back wrong");
   chk_swrst_bit: assert property (
      rd_in && addr_in == adc_cfg_pkg::ADDR_RESET |=> !rdata_out[7])
      else $error("reset bit did not clear");
   chk_shared_ctl: assert property (
      !mode[6] |-> loop_on_out[1] == loop_on_out[0]
      && noise_shaping_feature_out[1] == noise_shaping_feature_out[0])
      else $error("channels differ in shared mode");
   chk_loop_a: assert property (loop_on_out[0] == le_a)
      else $error("channel A loop enable wrong");
   chk_zero_word: assert property (
      data_valid_out && $past(pat) == 3'h1 && !$past(mode[6])
      |-> data_a_out == '0 && data_b_out == '0)
      else $error("zero pattern wrong");
   chk_user_word: assert property (
      data_valid_out && $past(pat) == 3'h5 |-> data_a_out == WIDTH'($past({hi[5:0], lo})))
      else $error("user word pattern wrong");
   chk_toggle_flip: assert property (
      data_valid_out && $past(data_valid_out) && $past(pat) == 3'h3 && $past(pat, 2) == 3'h3
      |-> data_a_out == ~$past(data_a_out))
      else $error("toggle pattern did not flip");
   chk_ramp_step: assert property (
      WIDTH == 14 && data_valid_out && $past(data_valid_out) && $past(pat) == 3'h4
      && $past(pat, 2) == 3'h4 |-> data_a_out == $past(data_a_out) + 1'b1)
      else $error("ramp did not step by one");
   chk_twos_msb: assert property (
      data_valid_out && $past(pat) == 3'h0 && $past(mode[2:1]) == 2'h2 && !$past(tw)
      && !$past(le_a) |-> data_a_out == ($past(sample_a_in) ^ {1'b1, {(WIDTH-1){1'b0}}}))
      else $error("twos complement output wrong");
   cov_ramp: cover property (data_valid_out && pat == 3'h4);
   cov_user: cover property (data_valid_out && pat == 3'h5);
   cov_swrst: cover property (wr_in && addr_in == adc_cfg_pkg::ADDR_RESET && wdata_in[7]);
endmodule // adc_output_config_bank_checker
bind adc_output_config_bank adc_output_config_bank_checker #(.WIDTH(WIDTH))
   i_adc_output_config_bank_checker (.clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in,
   .rd_in, .rdata_out, .sample_valid_in, .sample_a_in, .sample_b_in, .data_a_out,
   .data_b_out, .data_valid_out, .loop_on_out, .noise_shaping_feature_out);
`default_nettype wire

/* File: sim/adc_sample_source.sv */
// Behavioural converter core feeding offset-binary samples to the bank.
// Assumes the bench raises run_in once reset has been released.
`timescale 1ns/10ps
`default_nettype none
module adc_sample_source #(
   parameter int WIDTH = 14
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic run_in,
   output logic valid_out,
   output logic [WIDTH-1:0] a_out,
   output logic [WIDTH-1:0] b_out
);
   logic [WIDTH-1:0] cnt;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt <= '0;
         valid_out <= 1'b0;
         a_out <= '0;
         b_out <= '0;
      end else begin
         valid_out <= run_in;
         if (run_in) begin
            cnt <= cnt + 1'b1;
            a_out <= WIDTH'(cnt * 11);
            b_out <= ~WIDTH'(cnt * 5);
         end else begin
            // Idle lines flip so that a stale word can never pass for fresh data.
            a_out <= ~a_out;
            b_out <= ~b_out;
         end
      end
   end
endmodule // adc_sample_source
`default_nettype wire

/* File: sim/tb_adc_output_config_bank.sv */
// Self-checking bench for the converter output register bank.
// Assumes the 14-bit build and a sample source that runs every cycle.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_output_config_bank;
   logic clk_in, arst_n_in, wr_in, rd_in, run, sample_valid_in, data_valid_out;
   logic [7:0] addr_in, wdata_in, rdata_out;
   logic [13:0] sample_a_in, sample_b_in, data_a_out, data_b_out;
   logic [1:0] loop_on_out, noise_shaping_feature_out;
   int n_mismatch = 0;
   int n_checks = 0;
   adc_output_config_bank i_adc_output_config_bank (.clk_in, .arst_n_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .sample_valid_in, .sample_a_in, .sample_b_in, .data_a_out,
      .data_b_out, .data_valid_out, .loop_on_out, .noise_shaping_feature_out);
   adc_sample_source i_adc_sample_source (.clk_in, .arst_n_in, .run_in(run),
      .valid_out(sample_valid_in), .a_out(sample_a_in), .b_out(sample_b_in));
   always #5 clk_in = ~clk_in;
   task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_dat(input logic [13:0] got, input logic [13:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      cmp_reg(rdata_out, exp);
      @(posedge clk_in);
   endtask
   task automatic sample(output logic [13:0] sa, output logic [13:0] qa, output logic [13:0] qb);
      @(posedge clk_in);
      sa = sample_a_in;
      #1;
      qa = data_a_out;
      qb = data_b_out;
   endtask
   task automatic t_regs();
      rd_chk(adc_cfg_pkg::ADDR_GAIN_TC_A, 8'h00);
      wr_reg(8'h10, 8'hff);
      rd_chk(8'h10, 8'h00);
      wr_reg(adc_cfg_pkg::ADDR_USER_LO, 8'ha5);
      wr_reg(adc_cfg_pkg::ADDR_USER_HI, 8'hff);
      rd_chk(adc_cfg_pkg::ADDR_USER_LO, 8'ha5);
      rd_chk(adc_cfg_pkg::ADDR_USER_HI, 8'h3f);
   endtask
   task automatic t_patterns();
      logic [2:0] pc[3] = '{3'h1, 3'h2, 3'h5};
      logic [13:0] pe[3] = '{14'h0000, 14'h3fff, 14'h3fa5};
      logic [13:0] sa, q1, q2, qb;
      for (int i = 0; i < 3; i++) begin
         wr_reg(adc_cfg_pkg::ADDR_PAT_A, {5'h00, pc[i]});
         sample(sa, q1, qb);
         cmp_dat(q1, pe[i]);
         cmp_dat(qb, pe[i]);
      end
      wr_reg(adc_cfg_pkg::ADDR_PAT_A, 8'h03);
      sample(sa, q1, qb);
      sample(sa, q2, qb);
      cmp_dat(q1 ^ q2, 14'h3fff);
      cmp_dat(q1[0] ? q1 : ~q1, 14'h1555);
      wr_reg(adc_cfg_pkg::ADDR_PAT_A, 8'h04);
      sample(sa, q1, qb);
      for (int i = 0; i < 16390; i++) begin
         sample(sa, q2, qb);
         cmp_dat(q2, q1 + 14'h0001);
         q1 = q2;
      end
   endtask
   task automatic t_format();
      logic [13:0] sa, qa, qb;
      wr_reg(adc_cfg_pkg::ADDR_PAT_A, 8'h00);
      wr_reg(adc_cfg_pkg::ADDR_MODE_FMT, 8'h04);
      sample(sa, qa, qb);
      cmp_dat(qa, sa ^ 14'h2000);
      cmp_reg({7'h00, data_valid_out}, 8'h01);
      wr_reg(adc_cfg_pkg::ADDR_MODE_FMT, 8'h06);
      sample(sa, qa, qb);
      cmp_dat(qa, sa);
   endtask
   task automatic t_indep();
      logic [13:0] sa, qa, qb;
      wr_reg(adc_cfg_pkg::ADDR_MODE_FMT, 8'h46);
      wr_reg(adc_cfg_pkg::ADDR_PAT_A, 8'h01);
      wr_reg(adc_cfg_pkg::ADDR_PAT_B, 8'h02);
      sample(sa, qa, qb);
      cmp_dat(qa, 14'h0000);
      cmp_dat(qb, 14'h3fff);
      wr_reg(adc_cfg_pkg::ADDR_LOOP_EN_B, 8'h40);
      cmp_reg({6'h00, loop_on_out}, 8'h02);
      wr_reg(adc_cfg_pkg::ADDR_LOOP_EN_A, 8'h40);
      cmp_reg({6'h00, loop_on_out}, 8'h03);
      wr_reg(adc_cfg_pkg::ADDR_MODE_FMT, 8'h06);
      wr_reg(adc_cfg_pkg::ADDR_LOOP_EN_A, 8'h00);
      cmp_reg({6'h00, loop_on_out}, 8'h00);
      wr_reg(adc_cfg_pkg::ADDR_GAIN_TC_A, 8'hcb);
      rd_chk(adc_cfg_pkg::ADDR_GAIN_TC_A, 8'hcb);
      wr_reg(adc_cfg_pkg::ADDR_PED_A, 8'h20);
      rd_chk(adc_cfg_pkg::ADDR_PED_A, 8'h20);
      wr_reg(adc_cfg_pkg::ADDR_TRIM_A, 8'hff);
      rd_chk(adc_cfg_pkg::ADDR_TRIM_A, 8'hff);
      cmp_reg({6'h00, noise_shaping_feature_out}, 8'h03);
      wr_reg(adc_cfg_pkg::ADDR_RESET, 8'h80);
      rd_chk(adc_cfg_pkg::ADDR_RESET, 8'h00);
      rd_chk(adc_cfg_pkg::ADDR_USER_LO, 8'h00);
      rd_chk(adc_cfg_pkg::ADDR_GAIN_TC_A, 8'h00);
      cmp_reg({6'h00, noise_shaping_feature_out}, 8'h00);
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end
   initial begin
      {clk_in, arst_n_in, wr_in, rd_in, run, addr_in, wdata_in} = '0;
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      run <= 1'b1;
      @(posedge clk_in);
      t_regs();
      t_patterns();
      t_format();
      t_indep();
      summarize();
   end
endmodule // tb_adc_output_config_bank
`default_nettype wire
